// file: dv/smr_core_chk.sv
// port checker for the spi master register block
// assumes one sys_clk domain with srst synchronous active high
`timescale 1ns/1ps
module smr_core_chk (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // register port and link
    input wire bus_cs,
    input wire bus_wr,
    input wire bus_rd,
    input wire [2:0] bus_addr,
    input wire [15:0] bus_rdata,
    input wire sclk,
    input wire [15:0] sel_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // accesses to one register address
    sequence rd_at(int a);
        bus_cs && bus_rd && bus_addr == a;
    endsequence
    sequence wr_at(int a);
        bus_cs && bus_wr && bus_addr == a;
    endsequence
    // a cycle with no write of any register
    sequence no_wr;
        !(bus_cs && bus_wr);
    endsequence
    a_rdata_holds: assert property (!(bus_cs && bus_rd) |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    a_err_is_or: assert property (rd_at(2) |=> bus_rdata[8] == (bus_rdata[3] | bus_rdata[4]))
        else $error("error bit not the or of overruns");
    a_rsvd_zero: assert property (rd_at(4) |=> bus_rdata == 16'h0000)
        else $error("reserved address read nonzero");
    a_ctrl_bits: assert property (rd_at(3) |=> (bus_rdata & ~16'h05D8) == 16'h0000)
        else $error("undefined control bit set");
    a_stat_bits: assert property (rd_at(2) |=> (bus_rdata & ~16'h01F8) == 16'h0000)
        else $error("undefined status bit set");
    a_ctrl_reread: assert property (rd_at(3) ##1 no_wr ##1 rd_at(3)
        |=> $stable(bus_rdata))
        else $error("control read changed control");
    a_toe_cleared: assert property (wr_at(2) ##1 no_wr ##1 rd_at(2) |=> !bus_rdata[4])
        else $error("status write left transmit overrun");
    a_shift_selects: assert property (sclk |-> sel_n != 16'hFFFF)
        else $error("serial clock with no slave selected");
endmodule
bind smr_core smr_core_chk u_chk (.sys_clk, .srst, .bus_cs, .bus_wr, .bus_rd, .bus_addr,
    .bus_rdata, .sclk, .sel_n);

// file: dv/smr_slave_model.sv
// spi slave stand-in: replies with counting words, records words seen on mosi
// assumes data launched on sclk fall and sampled on rise, msb first
`timescale 1ns/1ps
module smr_slave_model (
    // serial link
    input wire sclk,
    input wire mosi,
    input wire [15:0] sel_n,
    output logic miso
);
    logic [15:0] out_r = 16'hC3A0;
    logic [15:0] nxt_w = 16'hC3A1;
    logic [15:0] in_r = 16'h0000;
    logic idle_r = 1'b0;
    int cnt = 0;
    logic [15:0] got[$];
    wire sel = (sel_n != 16'hFFFF);
    // released line wiggles so a stale bit never passes for data
    always #7 idle_r = !idle_r;
    assign miso = sel ? out_r[15] : idle_r;
    // capture on rise; reload per 16 bits since selects may stay low between words
    always @(posedge sclk) begin
        in_r = {in_r[14:0], mosi};
        cnt = cnt + 1;
        if (cnt == 16) begin
            got.push_back(in_r);
            out_r = nxt_w;
            nxt_w = nxt_w + 16'h0001;
            cnt = 0;
        end
    end
    // launch next bit on fall, not right after a reload
    always @(negedge sclk) if (cnt != 0) out_r = {out_r[14:0], 1'b0};
endmodule

// file: dv/testbench.sv
// self-checking bench for smr_core registers, status flags and selects
// assumes the slave stand-in answers with counting words from 16'hC3A0
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic link_clk = 1'b0;
    logic bus_cs = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [2:0] bus_addr = 3'h0;
    logic [15:0] bus_wdata = 16'h0000;
    wire [15:0] bus_rdata;
    wire [15:0] sel_n;
    wire irq;
    wire sclk;
    wire mosi;
    wire miso;
    int fails = 0;
    int tests_run = 0;
    int k;
    smr_core u_smr_core (.sys_clk, .srst, .bus_cs, .bus_wr, .bus_rd, .bus_addr, .bus_wdata,
        .bus_rdata, .irq, .link_clk, .miso, .sclk, .mosi, .sel_n);
    smr_slave_model u_smr_slave_model (.sclk, .mosi, .sel_n, .miso);
    initial forever #5 sys_clk = !sys_clk;
    // link clock free running, phase unrelated to sys_clk
    initial begin
        #3.3;
        forever #62.5 link_clk = !link_clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access, then an idle cycle so strobes never repeat by accident
    task acc(input logic w, input logic [2:0] a, input logic [15:0] d);
        bus_cs = 1'b1;
        bus_wr = w;
        bus_rd = !w;
        bus_addr = a;
        bus_wdata = d;
        @(negedge sys_clk);
        bus_cs = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        @(negedge sys_clk);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(bus_rdata, e);
    endtask
    // poll until shifter empty and holding free, bounded
    task wait_idle;
        for (int i = 0; i < 400; i++) begin
            acc(1'b0, 3'h2, 16'h0000);
            if (bus_rdata[6:5] === 2'b11) return;
        end
        fails++;
        finish_test;
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        @(negedge sys_clk);
        rd(3'h2, 16'h0060);
        rd(3'h3, 16'h0000);
        rd(3'h5, 16'h0001);
        rd(3'h4, 16'h0000);
        chk(sel_n, 16'hFFFF);
        $display("test reset values done");
        acc(1'b1, 3'h3, 16'hFFFF);
        rd(3'h3, 16'h05D8);
        rd(3'h3, 16'h05D8);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 3'h3, 16'h0080);
        chk({15'h0000, irq}, 16'h0000);
        $display("test control done");
        acc(1'b1, 3'h5, 16'h0006);
        acc(1'b1, 3'h1, 16'hA5C3);
        acc(1'b1, 3'h1, 16'h1234);
        acc(1'b1, 3'h1, 16'h5555);
        rd(3'h2, 16'h0110);
        chk(sel_n, 16'hFFF9);
        acc(1'b1, 3'h3, 16'h0110);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 3'h3, 16'h0008);
        chk({15'h0000, irq}, 16'h0000);
        acc(1'b1, 3'h2, 16'h0000);
        rd(3'h2, 16'h0000);
        wait_idle;
        chk(u_smr_slave_model.got[0], 16'hA5C3);
        chk(u_smr_slave_model.got[1], 16'h1234);
        chk(sel_n, 16'hFFFF);
        rd(3'h2, 16'h00E0);
        acc(1'b1, 3'h3, 16'h0080);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 3'h0, 16'hFFFF);
        rd(3'h0, 16'hC3A0);
        rd(3'h0, 16'hC3A1);
        rd(3'h2, 16'h0060);
        $display("test transmit done");
        // ten words unread: fifo fills, then rx holding is overwritten
        for (k = 0; k < 10; k++) begin
            acc(1'b1, 3'h1, 16'h0F00 + k[15:0]);
            wait_idle;
        end
        chk(u_smr_slave_model.got[11], 16'h0F09);
        rd(3'h2, 16'h01E8);
        acc(1'b1, 3'h3, 16'h0008);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 3'h3, 16'h0100);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 3'h2, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd(3'h2, 16'h00E0);
        rd(3'h0, 16'hC3A4);
        for (k = 0; k < 8; k++) acc(1'b0, 3'h0, 16'h0000);
        rd(3'h2, 16'h0060);
        $display("test overrun done");
        acc(1'b1, 3'h5, 16'h0001);
        acc(1'b1, 3'h3, 16'h0400);
        chk(sel_n, 16'hFFFE);
        acc(1'b1, 3'h3, 16'h0000);
        chk(sel_n, 16'hFFFF);
        $display("test forced select done");
        finish_test;
    end
endmodule

// file: src/smr_core.v
// register, status and select logic of an spi master, with a small shifter
// assumes a cpu-side register port on sys_clk and a free bit-rate clock on link_clk
// Notes on behaviour
// RULE1 - writing the transmit holding register clears transmit ready
// RULE2 - moving the held word into the shifter sets transmit ready
// RULE3 - write while not ready sets transmit overrun, word dropped, holding kept
// RULE4 - software should write transmit data only when transmit ready is set
// RULE5 - while shifter busy, held word waits and ready stays low
// RULE6 - status reads change no flag
// RULE7 - a status write clears both overruns and the error summary, except an overrun that sets in the same cycle
// RULE8 - word forced from a full fifo while receive ready sets receive overrun, overwrites
// RULE9 - shifter empty bit is low during a transfer, high when idle
// RULE10 - transmit ready reads one whenever the holding register is empty
// RULE11 - receive ready reads one whenever the receive register holds a word
// RULE12 - error bit is the or of both overrun flags
// RULE13 - control reads have no side effect
// RULE14 - interrupt asserts when any flag and its enable are both set
// RULE15 - control bits 3 and 4 enable receive and transmit overrun interrupts
// RULE16 - control bits 6 and 7 enable transmit and receive ready interrupts
// RULE17 - control bit 8 enables interrupt on the error summary
// RULE18 - control bit 10 holds masked selects asserted regardless of shifting
// RULE19 - reset clears control, disabling interrupts and all selects
// RULE20 - during a shift only masked slaves are selected
// RULE21 - several mask bits may be set, selecting those slaves together
// RULE22 - reset loads the select mask with slave 0 selected
// RULE23 - reading receive data clears receive ready; writing it does nothing
// RULE24 - word addresses 0 rx, 1 tx, 2 status, 3 control, 5 mask
// RULE25 - undefined bits read as zero here, writes to them ignored
// RULE26 - select outputs are low to select, high otherwise
// RULE27 - reset clears overruns; transmit ready and shifter empty start at one
`timescale 1ns/1ps
`include "smr_regs.vh"

// small synchronous fifo, first word falls through on the output
module smr_fifo #(
    parameter W = 16,
    parameter D = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // fill side
    input wire in_valid,
    input wire [W-1:0] in_data,
    output wire in_ready,
    // drain side
    output wire out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    // count at which the fifo refuses more words
    localparam [AW:0] CNT_FULL = D;

    assign in_ready = (cnt_r != CNT_FULL);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; pointers and count do
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // pointer and occupancy bookkeeping
    always @(posedge sys_clk) begin
        if (srst) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

module smr_core (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // register port
    input wire bus_cs,
    input wire bus_wr,
    input wire bus_rd,
    input wire [2:0] bus_addr,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata,
    // interrupt
    output reg irq,
    // serial link
    input wire link_clk,
    input wire miso,
    output reg sclk,
    output reg mosi,
    output reg [15:0] sel_n
);
    reg [15:0] tx_hold_r;
    reg [15:0] rx_hold_r;
    reg [15:0] ctrl_r;
    reg [15:0] selmask_r;
    reg trdy_r;
    reg rrdy_r;
    reg roe_r;
    reg toe_r;
    reg busy_r;
    reg [15:0] tx_sh_r;
    reg [15:0] rx_sh_r;
    reg [4:0] bit_cnt_r;
    reg push_r;
    reg [15:0] push_data_r;
    reg lclk_m_r;
    reg lclk_s_r;
    reg lclk_d_r;
    reg miso_m_r;
    reg miso_s_r;
    reg [15:0] status_nxt;
    reg irq_nxt;
    reg armed_r;
    wire wr_tx;
    wire wr_st;
    wire rd_rx;
    wire lclk_rise;
    wire lclk_fall;
    wire start;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire fifo_pop;
    wire fifo_out_ready;
    wire wr_ctrl;
    wire wr_mask;
    wire err_sum;

    // one access strobe aimed at one word address; shared by every decode
    function reg_hit;
        input cs;
        input strobe;
        input [2:0] addr;
        input [2:0] target;
        begin
            reg_hit = cs && strobe && (addr == target);
        end
    endfunction

    // decoded register strobes; an access to address 4 matches none of them
    assign wr_tx = reg_hit(bus_cs, bus_wr, bus_addr, `SMR_ADDR_TXDATA);
    assign wr_st = reg_hit(bus_cs, bus_wr, bus_addr, `SMR_ADDR_STATUS);
    assign wr_ctrl = reg_hit(bus_cs, bus_wr, bus_addr, `SMR_ADDR_CONTROL);
    assign wr_mask = reg_hit(bus_cs, bus_wr, bus_addr, `SMR_ADDR_SELMASK);
    assign rd_rx = reg_hit(bus_cs, bus_rd, bus_addr, `SMR_ADDR_RXDATA);
    // error summary feeds both the status word and the interrupt
    assign err_sum = roe_r || toe_r; // RULE12
    assign lclk_rise = lclk_s_r && !lclk_d_r;
    assign lclk_fall = !lclk_s_r && lclk_d_r;
    // a word may only start when the receive fifo has room for its result
    assign start = !trdy_r && !busy_r && fifo_in_ready; // RULE5
    // drain when the holding register is free, or force it when the fifo is
    // full so the shifter is never starved for long
    assign fifo_out_ready = !rrdy_r || !fifo_in_ready;
    assign fifo_pop = fifo_out_valid && fifo_out_ready;

    // two-flop synchronisers for the link clock and miso
    always @(posedge sys_clk) begin
        if (srst) begin
            lclk_m_r <= 1'b0;
            lclk_s_r <= 1'b0;
            lclk_d_r <= 1'b0;
            miso_m_r <= 1'b0;
            miso_s_r <= 1'b0;
        end else begin
            lclk_m_r <= link_clk;
            lclk_s_r <= lclk_m_r;
            lclk_d_r <= lclk_s_r;
            miso_m_r <= miso;
            miso_s_r <= miso_m_r;
        end
    end

    // status word as software sees it; undefined bits read zero
    always @* begin
        status_nxt = 16'h0000;
        status_nxt[`SMR_ST_ROE] = roe_r;
        status_nxt[`SMR_ST_TOE] = toe_r;
        status_nxt[`SMR_ST_TMT] = !busy_r; // RULE9
        status_nxt[`SMR_ST_TRDY] = trdy_r; // RULE10
        status_nxt[`SMR_ST_RRDY] = rrdy_r; // RULE11
        status_nxt[`SMR_ST_ERR] = err_sum; // RULE12
    end

    // transmit holding register and its handshake
    always @(posedge sys_clk) begin
        if (srst) begin
            tx_hold_r <= 16'h0000;
            trdy_r <= 1'b1; // RULE27
            toe_r <= 1'b0;
        end else begin
            if (wr_tx && trdy_r) begin
                tx_hold_r <= bus_wdata;
                trdy_r <= 1'b0; // RULE1
            end else if (start) begin
                trdy_r <= 1'b1; // RULE2
            end
            // an overrun in the same cycle as a status write still sticks
            if (wr_tx && !trdy_r) begin
                toe_r <= 1'b1; // RULE3
            end else if (wr_st) begin
                toe_r <= 1'b0; // RULE7
            end
        end
    end

    // receive holding register fed from the fifo
    always @(posedge sys_clk) begin
        if (srst) begin
            rx_hold_r <= 16'h0000;
            rrdy_r <= 1'b0;
            roe_r <= 1'b0;
        end else begin
            if (fifo_pop) begin
                rx_hold_r <= fifo_out_data; // RULE8
                rrdy_r <= 1'b1;
            end else if (rd_rx) begin
                rrdy_r <= 1'b0; // RULE23
            end
            if (fifo_pop && rrdy_r && !rd_rx) begin
                roe_r <= 1'b1; // RULE8
            end else if (wr_st) begin
                roe_r <= 1'b0; // RULE7
            end
        end
    end

    // control and select mask; only defined bits are writable
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= `SMR_CTRL_RST; // RULE19
            selmask_r <= `SMR_SEL_RST; // RULE22
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= bus_wdata & `SMR_CTRL_WMASK; // RULE25
            end
            // mask is taken whole, so any mix of slaves can share a frame
            if (wr_mask) begin
                selmask_r <= bus_wdata; // RULE21
            end
        end
    end

    // registered read data; reads never touch flags except rx ready
    always @(posedge sys_clk) begin
        if (srst) begin
            bus_rdata <= 16'h0000;
        end else if (bus_cs && bus_rd) begin
            case (bus_addr) // RULE24
                `SMR_ADDR_RXDATA: bus_rdata <= rx_hold_r;
                `SMR_ADDR_STATUS: bus_rdata <= status_nxt; // RULE6
                `SMR_ADDR_CONTROL: bus_rdata <= ctrl_r; // RULE13
                `SMR_ADDR_SELMASK: bus_rdata <= selmask_r;
                default: bus_rdata <= 16'h0000;
            endcase
        end
    end

    // shifter: sample miso on link rise, advance mosi on link fall; the
    // first fall after a start only arms it, which gives the miso
    // synchroniser and the selects time to settle before the first rise
    always @(posedge sys_clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            armed_r <= 1'b0;
            tx_sh_r <= 16'h0000;
            rx_sh_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            push_r <= 1'b0;
            push_data_r <= 16'h0000;
            mosi <= 1'b0;
        end else begin
            push_r <= 1'b0;
            if (start) begin
                busy_r <= 1'b1;
                armed_r <= 1'b0;
                mosi <= tx_hold_r[15];
                tx_sh_r <= {tx_hold_r[14:0], 1'b0};
                bit_cnt_r <= 5'h00;
            end else if (busy_r && armed_r && lclk_rise) begin
                rx_sh_r <= {rx_sh_r[14:0], miso_s_r};
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == `SMR_LAST_BIT) begin
                    busy_r <= 1'b0;
                    push_r <= 1'b1;
                    push_data_r <= {rx_sh_r[14:0], miso_s_r};
                end
            end else if (busy_r && lclk_fall) begin
                // a fall before any counted rise must not drop the msb
                if (armed_r) begin
                    mosi <= tx_sh_r[15];
                    tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                end
                armed_r <= 1'b1;
            end
        end
    end

    // interrupt request before its flop; each flag gated by its own enable
    always @* begin
        irq_nxt = 1'b0;
        if (roe_r && ctrl_r[`SMR_CT_RECEIVE_OVERRUN_IRQ_EN]) begin // RULE15
            irq_nxt = 1'b1;
        end
        if (toe_r && ctrl_r[`SMR_CT_TRANSMIT_OVERRUN_IRQ_EN]) begin // RULE15
            irq_nxt = 1'b1;
        end
        if (trdy_r && ctrl_r[`SMR_CT_TRANSMIT_READY_IRQ_EN]) begin // RULE16
            irq_nxt = 1'b1;
        end
        if (rrdy_r && ctrl_r[`SMR_CT_RECEIVE_READY_IRQ_EN]) begin // RULE16
            irq_nxt = 1'b1;
        end
        if (err_sum && ctrl_r[`SMR_CT_IE]) begin // RULE17
            irq_nxt = 1'b1;
        end
    end

    // serial clock: rises only on a counted link rise, so the slave never
    // sees an edge that the shifter did not sample; idles low
    always @(posedge sys_clk) begin
        if (srst) begin
            sclk <= 1'b0;
        end else if (!busy_r) begin
            sclk <= 1'b0;
        end else if (armed_r && lclk_rise) begin
            sclk <= 1'b1;
        end else if (lclk_fall) begin
            sclk <= 1'b0;
        end
    end

    // selects and interrupt, all from flops
    always @(posedge sys_clk) begin
        if (srst) begin
            sel_n <= 16'hFFFF;
            irq <= 1'b0;
        end else begin
            // force-hold keeps selects low across words for long frames
            if (busy_r || ctrl_r[`SMR_CT_SSO]) begin // RULE18
                sel_n <= ~selmask_r; // RULE20 RULE26
            end else begin
                sel_n <= 16'hFFFF;
            end
            irq <= irq_nxt; // RULE14
        end
    end

    // received words queue here before the holding register
    smr_fifo #(
        .W(`SMR_WORD_BITS),
        .D(`SMR_FIFO_DEPTH),
        .AW(`SMR_FIFO_AW)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(push_r),
        .in_data(push_data_r),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );
endmodule

// file: src/smr_regs.vh
// register window constants for the spi master register/status block
// assumes word addressing on a 3-bit register address port
`ifndef SMR_REGS_VH
`define SMR_REGS_VH
`define SMR_ADDR_RXDATA 3'h0
`define SMR_ADDR_TXDATA 3'h1
`define SMR_ADDR_STATUS 3'h2
`define SMR_ADDR_CONTROL 3'h3
`define SMR_ADDR_RSVD 3'h4
`define SMR_ADDR_SELMASK 3'h5
`define SMR_ST_ROE 3
`define SMR_ST_TOE 4
`define SMR_ST_TMT 5
`define SMR_ST_TRDY 6
`define SMR_ST_RRDY 7
`define SMR_ST_ERR 8
`define SMR_CT_RECEIVE_OVERRUN_IRQ_EN 3
`define SMR_CT_TRANSMIT_OVERRUN_IRQ_EN 4
`define SMR_CT_TRANSMIT_READY_IRQ_EN 6
`define SMR_CT_RECEIVE_READY_IRQ_EN 7
`define SMR_CT_IE 8
`define SMR_CT_SSO 10
`define SMR_CTRL_RST 16'h0000
`define SMR_CTRL_WMASK 16'h05D8
`define SMR_SEL_RST 16'h0001
`define SMR_WORD_BITS 16
`define SMR_LAST_BIT 5'h0F
`define SMR_FIFO_DEPTH 8
`define SMR_FIFO_AW 3
`endif
